// file: hw/cme_pkg.sv
// Shared constants, types and helpers of the CCM and MAC check engine
package cme_pkg;

  // Register byte offsets on the Wishbone slave
  localparam logic [11:0] CME_OFS_OPA = 12'h000;
  localparam logic [11:0] CME_OFS_OPB = 12'h004;
  localparam logic [11:0] CME_OFS_ISSUE = 12'h008;
  localparam logic [11:0] CME_OFS_STAT = 12'h00C;
  localparam logic [11:0] CME_OFS_IRQ_ST = 12'h010;
  localparam logic [11:0] CME_OFS_IRQ_MSK = 12'h014;
  localparam logic [11:0] CME_OFS_RAM = 12'h400;

  // Field positions
  localparam int CME_OPA_A = 0;
  localparam int CME_OPA_E = 16;
  localparam int CME_OPB_K = 0;
  localparam int CME_OPB_N = 8;
  localparam int CME_OPB_C = 16;
  localparam int CME_OPB_F = 24;
  localparam int CME_ISS_OP = 0;
  localparam int CME_ISS_PRI = 1;
  localparam int CME_ISS_M = 2;

  // Interrupt status bits
  localparam int CME_IRQ_DONE_L = 0;
  localparam int CME_IRQ_DONE_H = 1;
  localparam int CME_IRQ_USAGE = 2;
  localparam int CME_IRQ_MEMADDR = 3;
  localparam int CME_IRQ_W = 4;
  localparam logic [CME_IRQ_W-1:0] CME_MSK_RST = 4'h0;

  // Memory and operand limits
  localparam int CME_RAM_BYTES = 768;
  localparam logic [13:0] CME_RAM_END = 14'h0300;
  localparam logic [8:0] CME_CCM_MAX = 9'h080;
  localparam logic [13:0] CME_BLK_BYTES = 14'h0010;
  localparam int CME_ROUNDS = 4;

  // Operation codes
  localparam logic CME_OP_MAC = 1'b0;
  localparam logic CME_OP_CCM = 1'b1;

  // One security instruction with its operands
  typedef struct packed {
    logic op;
    logic pri;
    logic [2:0] m;
    logic [7:0] k;
    logic [7:0] n;
    logic [6:0] c;
    logic [6:0] f;
    logic [11:0] a;
    logic [11:0] e;
  } cme_cmd_t;

  // Write port of the data memory
  typedef struct packed {
    logic we;
    logic [9:0] addr;
    logic [7:0] data;
  } cme_ram_wr_t;

  typedef enum logic [2:0] {
    CME_IDLE,
    CME_KEY,
    CME_CTR,
    CME_PFX,
    CME_DATA,
    CME_FLUSH,
    CME_TAG
  } cme_phase_t;

  // Integrity code length in bytes for the size field
  function automatic logic [4:0] cme_mlen(input logic [1:0] m);
    case (m)
      2'h1: return 5'h04;
      2'h2: return 5'h08;
      2'h3: return 5'h10;
      default: return 5'h00;
    endcase
  endfunction : cme_mlen

  // Compact keyed mixing permutation used as the block cipher core
  function automatic logic [127:0] cme_mix(input logic [127:0] key, input logic [127:0] blk);
    logic [127:0] s;
    s = blk;
    for (int r = 0; r < CME_ROUNDS; r++) begin
      s = s ^ key;
      s = {s[94:0], s[127:95]} ^ {s[63:0], s[127:64]} ^ {8'(r + 1), 120'h0};
    end
    return s ^ key;
  endfunction : cme_mix

endpackage : cme_pkg

// file: hw/cme_ram.sv
// Byte-wide data memory with one registered read port and one write port
`timescale 1ns/1ps
module cme_ram
  import cme_pkg::*;
(
  input wire logic clk_i,            // System clock
  input wire logic ce_i,             // Clock enable
  input wire logic [9:0] rd_addr_i,  // Read byte address
  input wire cme_ram_wr_t wr_i,      // Write request
  output logic [7:0] rd_data_o       // Read data, one cycle after address
);

  logic [7:0] mem [0:CME_RAM_BYTES-1];

  // Write then registered read
  always_ff @(posedge clk_i) begin
    if (ce_i) begin
      if (wr_i.we) begin
        mem[wr_i.addr] <= wr_i.data;
      end
      rd_data_o <= mem[rd_addr_i];
    end
  end

endmodule : cme_ram

// file: hw/cme_engine.sv
// CCM encryption and reverse MAC check engine with Wishbone registers
// Summary of operation
// - MAC check reads C bytes from A, key 16K
// - Priority bit selects low or high level
// - Compute 4/8/16 byte code, compare after data
// - Separate pass/fail bit per priority
// - Size field zero always reports pass
// - Prefix bit clear prepends byte count, in MAC check only
// - Prefix bit set authenticates without prefix
// - Same priority already active raises busy_priority_violation_exception
// - Completion exception per priority, raised unless the issue is refused as busy or over length
// - CCM authenticates header, encrypts payload, key, counter
// - Zero destination means source plus header
// - CCM writes ciphertext then 0/4/8/16 code bytes
// - Header plus payload above 128 is busy_priority_violation_exception
`timescale 1ns/1ps
module cme_engine
  import cme_pkg::*;
(
  input wire logic clk_i,             // System clock
  input wire logic rst_i,             // Synchronous reset, active high
  input wire logic ce_i,              // Clock enable, freezes state when low
  input wire logic wb_cyc_i,          // Wishbone cycle
  input wire logic wb_stb_i,          // Wishbone strobe
  input wire logic wb_we_i,           // Wishbone write enable
  input wire logic [11:0] wb_adr_i,   // Wishbone byte address
  input wire logic [3:0] wb_sel_i,    // Wishbone byte selects
  input wire logic [31:0] wb_dat_i,   // Wishbone write data
  output logic wb_ack_o,              // Wishbone acknowledge
  output logic [31:0] wb_dat_o,       // Wishbone read data
  output logic irq_o,                 // Level interrupt
  output logic [7:0] status_o         // Status byte of the instruction interface
);

  typedef struct packed {
    cme_phase_t ph;
    logic half;
    cme_cmd_t stg;
    cme_cmd_t cur;
    cme_cmd_t pnd_l;
    cme_cmd_t pnd_h;
    logic pv_l;
    logic pv_h;
    logic [127:0] key;
    logic [127:0] ctr;
    logic [127:0] x;
    logic [127:0] blk;
    logic [3:0] bpos;
    logic [7:0] idx;
    logic [4:0] j;
    logic mism;
    logic auth_h;
    logic auth_l;
    logic [CME_IRQ_W-1:0] irq_st;
    logic [CME_IRQ_W-1:0] irq_msk;
    logic ack;
    logic rdp;
    logic [31:0] dat;
    logic irq;
    logic [7:0] sts;
  } cme_reg_t;

  cme_reg_t r_ff;
  cme_reg_t nxt_r;
  logic [7:0] ram_rd;
  logic [9:0] ram_ra;
  cme_ram_wr_t ram_w;
  logic [CME_IRQ_W-1:0] ev;
  logic req;
  logic is_ram;
  logic [9:0] wb_ba;
  logic [31:0] wmask;
  logic iss;
  cme_cmd_t icmd;
  logic ibusy;
  logic ilong;
  logic ibad;
  logic [7:0] ilen;
  logic [4:0] imlen;
  logic [11:0] idst;
  logic [4:0] mlen;
  logic [7:0] total;
  logic [11:0] dst;
  logic [7:0] q;
  logic [127:0] ctr_q;
  logic [127:0] ctr_0;
  logic [127:0] ks;
  logic [127:0] s0;
  logic [127:0] blk_n;
  logic act_h;
  logic act_l;

  cme_ram u_ram (
    .clk_i(clk_i),
    .ce_i(ce_i),
    .rd_addr_i(ram_ra),
    .wr_i(ram_w),
    .rd_data_o(ram_rd)
  );

  // Bus decode
  assign req = wb_cyc_i & wb_stb_i & ~r_ff.ack;
  assign is_ram = (wb_adr_i >= CME_OFS_RAM);
  assign wb_ba = 10'(wb_adr_i[11:2] - CME_OFS_RAM[11:2]);
  assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  // Active flags per priority level
  assign act_h = r_ff.pv_h | ((r_ff.ph != CME_IDLE) & r_ff.cur.pri);
  assign act_l = r_ff.pv_l | ((r_ff.ph != CME_IDLE) & ~r_ff.cur.pri);

  // Instruction issue checks
  assign iss = req & wb_we_i & ~is_ram & (wb_adr_i == CME_OFS_ISSUE) & wb_sel_i[0];
  always_comb begin
    icmd = r_ff.stg;
    icmd.op = wb_dat_i[CME_ISS_OP];
    icmd.pri = wb_dat_i[CME_ISS_PRI];
    icmd.m = wb_dat_i[CME_ISS_M +: 3];
  end
  assign ibusy = icmd.pri ? act_h : act_l;
  assign ilen = icmd.op ? ({1'b0, icmd.c} + {1'b0, icmd.f}) : {1'b0, icmd.c};
  assign ilong = icmd.op & ({1'b0, ilen} > CME_CCM_MAX);
  assign imlen = cme_mlen(icmd.m[1:0]);
  assign idst = (icmd.e == 12'h000) ? 12'(icmd.a + {5'h00, icmd.f}) : icmd.e;
  // Every touched byte range must stay inside the data memory
  assign ibad = (({2'h0, icmd.k, 4'h0} + CME_BLK_BYTES) > CME_RAM_END)
    | (({2'h0, icmd.a} + {6'h00, ilen} + (icmd.op ? 14'h0000 : {9'h000, imlen})) > CME_RAM_END)
    | (icmd.op & (({2'h0, icmd.n, 4'h0} + CME_BLK_BYTES) > CME_RAM_END))
    | (icmd.op & (({2'h0, idst} + {7'h00, icmd.c} + {9'h000, imlen}) > CME_RAM_END));

  // Datapath of the running instruction
  assign mlen = cme_mlen(r_ff.cur.m[1:0]);
  assign total = r_ff.cur.op ? ({1'b0, r_ff.cur.c} + {1'b0, r_ff.cur.f}) : {1'b0, r_ff.cur.c};
  assign dst = (r_ff.cur.e == 12'h000) ? 12'(r_ff.cur.a + {5'h00, r_ff.cur.f}) : r_ff.cur.e;
  assign q = r_ff.idx - {1'b0, r_ff.cur.f};
  always_comb begin
    ctr_q = r_ff.ctr;
    ctr_q[127:120] = r_ff.ctr[127:120] + {5'h00, q[6:4]} + 8'h01;
    ctr_0 = r_ff.ctr;
    ctr_0[127:120] = 8'h00;
  end
  assign ks = cme_mix(r_ff.key, ctr_q);
  assign s0 = cme_mix(r_ff.key, ctr_0);

  // Next state of the whole block
  always_comb begin
    nxt_r = r_ff;
    ev = '0;
    ram_ra = 10'h000;
    ram_w = '0;
    blk_n = r_ff.blk;
    nxt_r.ack = 1'b0;
    // Bus slave
    if (r_ff.rdp) begin
      nxt_r.rdp = 1'b0;
      nxt_r.ack = 1'b1;
      nxt_r.dat = {24'h000000, ram_rd};
    end else if (req & is_ram) begin
      if (r_ff.ph == CME_IDLE) begin
        if (wb_we_i) begin
          ram_w.we = wb_sel_i[0];
          ram_w.addr = wb_ba;
          ram_w.data = wb_dat_i[7:0];
          nxt_r.ack = 1'b1;
        end else begin
          ram_ra = wb_ba;
          nxt_r.rdp = 1'b1;
        end
      end
    end else if (req) begin
      nxt_r.ack = 1'b1;
      nxt_r.dat = 32'h00000000;
      case (wb_adr_i)
        CME_OFS_OPA: begin
          nxt_r.dat = {4'h0, r_ff.stg.e, 4'h0, r_ff.stg.a};
          if (wb_we_i) begin
            {nxt_r.stg.e, nxt_r.stg.a} = 24'((({4'h0, r_ff.stg.e, 4'h0, r_ff.stg.a} & ~wmask)
              | (wb_dat_i & wmask)) >> 0) | 24'h000000;
            nxt_r.stg.a = 12'((nxt_r.dat & ~wmask | wb_dat_i & wmask) >> CME_OPA_A);
            nxt_r.stg.e = 12'((nxt_r.dat & ~wmask | wb_dat_i & wmask) >> CME_OPA_E);
          end
        end
        CME_OFS_OPB: begin
          nxt_r.dat = {1'b0, r_ff.stg.f, 1'b0, r_ff.stg.c, r_ff.stg.n, r_ff.stg.k};
          if (wb_we_i) begin
            nxt_r.stg.k = 8'((nxt_r.dat & ~wmask | wb_dat_i & wmask) >> CME_OPB_K);
            nxt_r.stg.n = 8'((nxt_r.dat & ~wmask | wb_dat_i & wmask) >> CME_OPB_N);
            nxt_r.stg.c = 7'((nxt_r.dat & ~wmask | wb_dat_i & wmask) >> CME_OPB_C);
            nxt_r.stg.f = 7'((nxt_r.dat & ~wmask | wb_dat_i & wmask) >> CME_OPB_F);
          end
        end
        CME_OFS_STAT: nxt_r.dat = {16'h0000, r_ff.sts, 8'h00};
        CME_OFS_IRQ_ST: nxt_r.dat = {28'h0000000, r_ff.irq_st};
        CME_OFS_IRQ_MSK: begin
          nxt_r.dat = {28'h0000000, r_ff.irq_msk};
          if (wb_we_i & wb_sel_i[0]) begin
            nxt_r.irq_msk = wb_dat_i[CME_IRQ_W-1:0];
          end
        end
        default: nxt_r.dat = 32'h00000000;
      endcase
    end
    // Issue of a new instruction
    if (iss) begin
      if (ibusy | ilong) begin
        ev[CME_IRQ_USAGE] = 1'b1;
      end else if (ibad) begin
        ev[CME_IRQ_MEMADDR] = 1'b1;
        ev[icmd.pri ? CME_IRQ_DONE_H : CME_IRQ_DONE_L] = 1'b1;
      end else if (icmd.pri) begin
        nxt_r.pnd_h = icmd;
        nxt_r.pv_h = 1'b1;
      end else begin
        nxt_r.pnd_l = icmd;
        nxt_r.pv_l = 1'b1;
      end
    end
    // Instruction sequencer
    case (r_ff.ph)
      CME_IDLE: begin
        nxt_r.half = 1'b0;
        nxt_r.j = 5'h00;
        nxt_r.idx = 8'h00;
        nxt_r.bpos = 4'h0;
        nxt_r.x = '0;
        nxt_r.blk = '0;
        nxt_r.mism = 1'b0;
        if (r_ff.pv_h) begin
          nxt_r.cur = r_ff.pnd_h;
          nxt_r.pv_h = 1'b0;
          nxt_r.ph = CME_KEY;
        end else if (r_ff.pv_l) begin
          nxt_r.cur = r_ff.pnd_l;
          nxt_r.pv_l = 1'b0;
          nxt_r.ph = CME_KEY;
        end
      end
      CME_KEY, CME_CTR: begin
        ram_ra = (r_ff.ph == CME_KEY) ? {r_ff.cur.k[5:0], r_ff.j[3:0]}
          : {r_ff.cur.n[5:0], r_ff.j[3:0]};
        nxt_r.half = ~r_ff.half;
        if (r_ff.half) begin
          if (r_ff.ph == CME_KEY) begin
            nxt_r.key[8*r_ff.j[3:0] +: 8] = ram_rd;
          end else begin
            nxt_r.ctr[8*r_ff.j[3:0] +: 8] = ram_rd;
          end
          nxt_r.j = r_ff.j + 5'h01;
          if (r_ff.j == 5'h0F) begin
            nxt_r.j = 5'h00;
            if ((r_ff.ph == CME_KEY) & r_ff.cur.op) begin
              nxt_r.ph = CME_CTR;
            end else if (~r_ff.cur.op & ~r_ff.cur.m[2]) begin
              nxt_r.ph = CME_PFX;
            end else begin
              nxt_r.ph = (total == 8'h00) ? CME_FLUSH : CME_DATA;
            end
          end
        end
      end
      CME_PFX: begin
        nxt_r.blk[7:0] = {1'b0, r_ff.cur.c};
        nxt_r.bpos = 4'h1;
        nxt_r.ph = (total == 8'h00) ? CME_FLUSH : CME_DATA;
      end
      CME_DATA: begin
        ram_ra = 10'(r_ff.cur.a + {4'h0, r_ff.idx});
        nxt_r.half = ~r_ff.half;
        if (r_ff.half) begin
          if (r_ff.cur.op & (r_ff.idx >= {1'b0, r_ff.cur.f})) begin
            ram_w.we = 1'b1;
            ram_w.addr = 10'(dst + {4'h0, q});
            ram_w.data = ram_rd ^ ks[8*q[3:0] +: 8];
          end
          blk_n[8*r_ff.bpos +: 8] = ram_rd;
          nxt_r.bpos = r_ff.bpos + 4'h1;
          nxt_r.blk = blk_n;
          if (r_ff.bpos == 4'hF) begin
            nxt_r.x = cme_mix(r_ff.key, r_ff.x ^ blk_n);
            nxt_r.blk = '0;
          end
          nxt_r.idx = r_ff.idx + 8'h01;
          if (r_ff.idx == total - 8'h01) begin
            nxt_r.ph = CME_FLUSH;
          end
        end
      end
      CME_FLUSH: begin
        if (r_ff.bpos != 4'h0) begin
          nxt_r.x = cme_mix(r_ff.key, r_ff.x ^ r_ff.blk);
        end
        nxt_r.bpos = 4'h0;
        nxt_r.ph = CME_TAG;
      end
      CME_TAG: begin
        ram_ra = 10'(r_ff.cur.a + {5'h00, r_ff.cur.c} + {7'h00, r_ff.j});
        if (r_ff.j == mlen) begin
          ev[r_ff.cur.pri ? CME_IRQ_DONE_H : CME_IRQ_DONE_L] = 1'b1;
          if (~r_ff.cur.op) begin
            if (r_ff.cur.pri) begin
              nxt_r.auth_h = (mlen == 5'h00) | ~r_ff.mism;
            end else begin
              nxt_r.auth_l = (mlen == 5'h00) | ~r_ff.mism;
            end
          end
          nxt_r.ph = CME_IDLE;
        end else if (r_ff.cur.op) begin
          ram_w.we = 1'b1;
          ram_w.addr = 10'(dst + {5'h00, r_ff.cur.c} + {7'h00, r_ff.j});
          ram_w.data = r_ff.x[8*r_ff.j[3:0] +: 8] ^ s0[8*r_ff.j[3:0] +: 8];
          nxt_r.j = r_ff.j + 5'h01;
        end else begin
          nxt_r.half = ~r_ff.half;
          if (r_ff.half) begin
            if (ram_rd != r_ff.x[8*r_ff.j[3:0] +: 8]) begin
              nxt_r.mism = 1'b1;
            end
            nxt_r.j = r_ff.j + 5'h01;
          end
        end
      end
      default: nxt_r.ph = CME_IDLE;
    endcase
    // Sticky events, write one to clear, a new event wins
    if (req & ~is_ram & wb_we_i & wb_sel_i[0] & (wb_adr_i == CME_OFS_IRQ_ST)) begin
      nxt_r.irq_st = r_ff.irq_st & ~wb_dat_i[CME_IRQ_W-1:0];
    end
    nxt_r.irq_st = nxt_r.irq_st | ev;
    nxt_r.irq = |(nxt_r.irq_st & nxt_r.irq_msk);
    nxt_r.sts = {nxt_r.auth_h, nxt_r.auth_l,
      nxt_r.pv_h | ((nxt_r.ph != CME_IDLE) & nxt_r.cur.pri),
      nxt_r.pv_l | ((nxt_r.ph != CME_IDLE) & ~nxt_r.cur.pri), nxt_r.irq_st};
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r_ff <= '0;
      r_ff.ph <= CME_IDLE;
      r_ff.irq_msk <= CME_MSK_RST;
    end else if (ce_i) begin
      r_ff <= nxt_r;
    end
  end

  assign wb_ack_o = r_ff.ack;
  assign wb_dat_o = r_ff.dat;
  assign irq_o = r_ff.irq;
  assign status_o = r_ff.sts;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence issue_busy_s;
    ce_i && iss && ibusy;
  endsequence
  sequence tag_end_s;
    ce_i && r_ff.ph == CME_TAG && r_ff.j == mlen;
  endsequence

  busy_usage_a: assert property (issue_busy_s |=> r_ff.irq_st[CME_IRQ_USAGE])
    else $error("busy issue did not raise busy_priority_violation_exception");
  ccm_len_a: assert property (ce_i && iss && !ibusy && icmd.op && ilen > 8'h80
    |=> r_ff.irq_st[CME_IRQ_USAGE] && !$past(r_ff.pv_l) == !r_ff.pv_l)
    else $error("long CCM not refused");
  bad_range_a: assert property (ce_i && iss && !ibusy && !ilong && ibad
    |=> r_ff.irq_st[CME_IRQ_MEMADDR] && $past(r_ff.pv_h) == r_ff.pv_h)
    else $error("bad range accepted");
  done_pri_a: assert property (tag_end_s |=> r_ff.ph == CME_IDLE
    && r_ff.irq_st[$past(r_ff.cur.pri) ? CME_IRQ_DONE_H : CME_IRQ_DONE_L])
    else $error("completion not flagged");
  auth_skip_a: assert property (tag_end_s and (!r_ff.cur.op && r_ff.cur.m[1:0] == 2'h0)
    |=> (r_ff.cur.pri ? r_ff.auth_h : r_ff.auth_l))
    else $error("size zero did not pass");
  auth_fail_a: assert property (tag_end_s and (!r_ff.cur.op && mlen != 5'h00 && r_ff.mism)
    |=> !(r_ff.cur.pri ? r_ff.auth_h : r_ff.auth_l))
    else $error("mismatch reported as pass");
  key_addr_a: assert property (r_ff.ph == CME_KEY
    |-> ram_ra == {r_ff.cur.k[5:0], r_ff.j[3:0]})
    else $error("key read address wrong");
  prefix_a: assert property (ce_i && r_ff.ph == CME_PFX
    |=> r_ff.blk[7:0] == {1'b0, r_ff.cur.c} && r_ff.bpos == 4'h1)
    else $error("length prefix missing");
  no_prefix_a: assert property (ce_i && r_ff.ph == CME_KEY && !r_ff.cur.op && r_ff.cur.m[2]
    |=> r_ff.ph != CME_PFX)
    else $error("prefix inserted when disabled");
  ccm_dst_a: assert property (r_ff.ph == CME_DATA && ram_w.we && r_ff.cur.e == 12'h000
    |-> ram_w.addr == 10'(r_ff.cur.a + {5'h00, r_ff.cur.f} + {4'h0, q}))
    else $error("in-place destination wrong");

endmodule : cme_engine

// file: verif/cme_host_model.sv
// Host model that issues Wishbone cycles and security instructions
`timescale 1ns/1ps
module cme_host_model
  import cme_pkg::*;
(
  input wire logic clk_i,           // System clock
  input wire logic wb_ack_i,        // Acknowledge from the engine
  input wire logic [31:0] wb_dat_i, // Read data from the engine
  output logic wb_cyc_o,            // Cycle
  output logic wb_stb_o,            // Strobe
  output logic wb_we_o,             // Write enable
  output logic [11:0] wb_adr_o,     // Byte address
  output logic [3:0] wb_sel_o,      // Byte selects
  output logic [31:0] wb_dat_o,     // Write data
  output logic hung_o               // An answer never came
);
  // Idle bus from time zero
  initial begin
    wb_cyc_o = 1'b0;
    wb_stb_o = 1'b0;
    wb_we_o = 1'b0;
    wb_adr_o = 12'h000;
    wb_sel_o = 4'hF;
    wb_dat_o = 32'h0;
    hung_o = 1'b0;
  end

  // One classic cycle, held until ack is sampled high at an edge
  task automatic xfer(input logic we, input logic [11:0] adr, input logic [31:0] wd,
                      output logic [31:0] rdv);
    int n;
    @(posedge clk_i);
    wb_cyc_o <= 1'b1;
    wb_stb_o <= 1'b1;
    wb_we_o <= we;
    wb_adr_o <= adr;
    wb_dat_o <= wd;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_i !== 1'b1 && n < 3000);
    rdv = wb_dat_i;
    wb_cyc_o <= 1'b0;
    wb_stb_o <= 1'b0;
    wb_we_o <= 1'b0;
    if (n >= 3000) hung_o <= 1'b1;
  endtask : xfer

  // Operands first, then the issue word with the priority bit
  task automatic issue(input logic op, input logic pri, input logic [2:0] m,
                       input logic [11:0] a, input logic [11:0] e, input logic [7:0] k,
                       input logic [7:0] n, input logic [6:0] c, input logic [6:0] f);
    logic [31:0] d;
    xfer(1'b1, CME_OFS_OPA, {4'h0, e, 4'h0, a}, d);
    xfer(1'b1, CME_OFS_OPB, {1'b0, f, 1'b0, c, n, k}, d);
    xfer(1'b1, CME_OFS_ISSUE, {27'h0, m, pri, op}, d);
  endtask : issue
endmodule : cme_host_model

// file: verif/cme_engine_bench.sv
// Self-checking bench of the CCM and MAC check engine
`timescale 1ns/1ps
module cme_engine_bench;
  import cme_pkg::*;
  typedef struct packed {
    logic wr;
    logic [11:0] adr;
    logic [31:0] wd;
    logic [31:0] ex;
  } cme_row_t;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc, stb, we, ack, irq_o, hung;
  logic [11:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, rd;
  logic [7:0] status_o;
  int n_errors = 0;
  int compares = 0;
  int chg;
  cme_row_t rows [8] = '{'{1'b0, CME_OFS_STAT, 32'h0, 32'h0}, '{1'b0, CME_OFS_IRQ_ST, 32'h0, 32'h0},
    '{1'b0, CME_OFS_IRQ_MSK, 32'h0, 32'h0}, '{1'b1, 12'h018, 32'hFFFFFFFF, 32'h0},
    '{1'b1, CME_OFS_IRQ_MSK, 32'h5, 32'h5}, '{1'b1, 12'h400, 32'h123456A5, 32'hA5},
    '{1'b1, 12'hFFC, 32'h3C, 32'h3C}, '{1'b1, CME_OFS_IRQ_MSK, 32'h0, 32'h0}};

  cme_engine u_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_ack_o(ack),
    .wb_dat_o(rdat), .irq_o(irq_o), .status_o(status_o));
  cme_host_model u_host (.clk_i(clk_i), .wb_ack_i(ack), .wb_dat_i(rdat), .wb_cyc_o(cyc),
    .wb_stb_o(stb), .wb_we_o(we), .wb_adr_o(adr), .wb_sel_o(sel), .wb_dat_o(wdat),
    .hung_o(hung));

  // 125 MHz clock
  initial begin
    forever #4 clk_i = ~clk_i;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish

  task automatic rdreg(input logic [11:0] a);
    u_host.xfer(1'b0, a, 32'h0, rd);
  endtask : rdreg

  task automatic clr();
    u_host.xfer(1'b1, CME_OFS_IRQ_ST, 32'hF, rd);
  endtask : clr

  // Polls the interrupt status until one bit is set, bounded
  task automatic wait_irq(input int b);
    int i;
    for (i = 0; i < 400; i++) begin
      rdreg(CME_OFS_IRQ_ST);
      if (rd[b] === 1'b1) break;
    end
    if (i == 400) begin
      n_errors++;
      $display("MISMATCH irq bit %0d expected 1 seen 0", b);
      tally_and_finish();
    end
  endtask : wait_irq

  task automatic fill(input int base, input int n, input logic [7:0] v0, input logic [7:0] st);
    for (int i = 0; i < n; i++) begin
      u_host.xfer(1'b1, 12'(12'h400 + 4 * (base + i)), {24'h0, v0 + 8'(i) * st}, rd);
    end
  endtask : fill

  task automatic rdram(input int i);
    u_host.xfer(1'b0, 12'(12'h400 + 4 * i), 32'h0, rd);
  endtask : rdram

  function automatic logic [31:0] pat(input int i);
    return {24'h0, 8'h5A + 8'(i) * 8'h03};
  endfunction : pat

  // A bus cycle that never answered ends the run
  always @(posedge hung) begin
    n_errors++;
    $display("MISMATCH bus ack expected 1 seen 0");
    tally_and_finish();
  end

  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (rows[i]) begin
      if (rows[i].wr) u_host.xfer(1'b1, rows[i].adr, rows[i].wd, rd);
      rdreg(rows[i].adr);
      check("register row", rd, rows[i].ex);
    end
    $display("test registers done");
    // Key and counter blocks, message bytes with a wrong received code
    fill(12'h200, 32, 8'h11, 8'h07);
    fill(0, 136, 8'h5A, 8'h03);
    fill(12'h180, 32, 8'hC3, 8'h00);
    u_host.issue(CME_OP_MAC, 1'b0, 3'b000, 12'h000, 12'h000, 8'h20, 8'h00, 7'd8, 7'd0);
    wait_irq(CME_IRQ_DONE_L);
    check("irq masked", 32'(irq_o), 32'h0);
    check("status size zero", 32'(status_o), 32'h41);
    u_host.xfer(1'b1, CME_OFS_IRQ_MSK, 32'h1, rd);
    rdreg(CME_OFS_STAT);
    check("stat register", rd, 32'h4100);
    check("irq unmasked", 32'(irq_o), 32'h1);
    clr();
    rdreg(CME_OFS_IRQ_ST);
    check("irq cleared", 32'(irq_o), 32'h0);
    u_host.issue(CME_OP_MAC, 1'b1, 3'b101, 12'h000, 12'h000, 8'h20, 8'h00, 7'd8, 7'd0);
    wait_irq(CME_IRQ_DONE_H);
    check("status high fail", 32'(status_o), 32'h42);
    u_host.issue(CME_OP_MAC, 1'b0, 3'b001, 12'h000, 12'h000, 8'h20, 8'h00, 7'd8, 7'd0);
    wait_irq(CME_IRQ_DONE_L);
    check("status low fail", 32'(status_o), 32'h03);
    clr();
    $display("test mac check done");
    // Same priority busy versus other priority
    u_host.issue(CME_OP_MAC, 1'b0, 3'b001, 12'h000, 12'h000, 8'h20, 8'h00, 7'd100, 7'd0);
    u_host.issue(CME_OP_MAC, 1'b1, 3'b001, 12'h000, 12'h000, 8'h20, 8'h00, 7'd8, 7'd0);
    rdreg(CME_OFS_IRQ_ST);
    check("other priority", rd & 32'h4, 32'h0);
    check("both active", 32'(status_o[5:4]), 32'h3);
    u_host.issue(CME_OP_MAC, 1'b0, 3'b001, 12'h000, 12'h000, 8'h20, 8'h00, 7'd8, 7'd0);
    rdreg(CME_OFS_IRQ_ST);
    check("same priority", rd & 32'h4, 32'h4);
    wait_irq(CME_IRQ_DONE_L);
    wait_irq(CME_IRQ_DONE_H);
    clr();
    $display("test usage done");
    u_host.issue(CME_OP_CCM, 1'b0, 3'b001, 12'h000, 12'h000, 8'h20, 8'h21, 7'd65, 7'd64);
    rdreg(CME_OFS_IRQ_ST);
    check("ccm over limit", rd, 32'h4);
    clr();
    u_host.issue(CME_OP_CCM, 1'b0, 3'b001, 12'h000, 12'h000, 8'h20, 8'h21, 7'd64, 7'd64);
    wait_irq(CME_IRQ_DONE_L);
    check("ccm at limit", rd, 32'h1);
    rdram(63);
    check("header kept", rd, pat(63));
    rdram(132);
    check("after tag kept", rd, pat(132));
    chg = 0;
    for (int i = 64; i < 132; i++) begin
      rdram(i);
      if (rd !== pat(i)) chg++;
    end
    check("in place rewrite", 32'(chg > 60), 32'h1);
    clr();
    // Code length per size field, written at a given destination
    for (int m = 0; m < 4; m++) begin
      u_host.issue(CME_OP_CCM, 1'b1, 3'(m), 12'h000, 12'h180, 8'h20, 8'h21, 7'd8, 7'd4);
      wait_irq(CME_IRQ_DONE_H);
      clr();
      rdram(12'h180 + 8 + ((m == 0) ? 0 : (2 << m)));
      check("code length", rd, 32'hC3);
    end
    $display("test ccm done");
    u_host.issue(CME_OP_MAC, 1'b1, 3'b001, 12'h2F8, 12'h000, 8'h20, 8'h00, 7'd16, 7'd0);
    wait_irq(CME_IRQ_DONE_H);
    check("source range", rd, 32'hA);
    clr();
    u_host.issue(CME_OP_CCM, 1'b0, 3'b001, 12'h000, 12'h000, 8'h30, 8'h21, 7'd8, 7'd4);
    wait_irq(CME_IRQ_DONE_L);
    check("key range", rd, 32'h9);
    $display("test range done");
    // Reset in the middle of an instruction
    u_host.issue(CME_OP_MAC, 1'b0, 3'b001, 12'h000, 12'h000, 8'h20, 8'h00, 7'd100, 7'd0);
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rdreg(CME_OFS_STAT);
    check("stat after reset", rd, 32'h0);
    check("status after reset", 32'(status_o), 32'h0);
    check("irq after reset", 32'(irq_o), 32'h0);
    $display("test reset done");
    tally_and_finish();
  end
endmodule : cme_engine_bench
